// File: design/dda_regs.svh
// Purpose: named constants for the converter host port.
// Assumes: 25 MHz system clock, 8-bit data path.
// Notes:   definitions only; included by bare name.
`ifndef DDA_REGS_SVH
`define DDA_REGS_SVH

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define DDA_DW         8
`define DDA_LATCH_RST  8'h00
`define DDA_SAR_RST    8'h00
`define DDA_SAR_MSB    8'h80
`define DDA_BIT_MSB    3'h7
`define DDA_BIT_LSB    3'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DDA_CLK_NS      40
`define DDA_T_CONV_NS   2000
`define DDA_CONV_BITS   8
// Longest time per bit, rounded down to whole clocks
`define DDA_CYC_PER_BIT ((`DDA_T_CONV_NS) / ((`DDA_CONV_BITS) * (`DDA_CLK_NS)))
`define DDA_DIV_W       8

`endif

// File: design/dda_pkg.sv
// Purpose: shared types of the converter host port.
// Assumes: pin bundle is sampled asynchronously.
// Notes:   constants live in dda_regs.svh.
package dda_pkg;

   // ----------------------------------------------------------------
   // Host pin bundle, all asynchronous to clk
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       cs_n;
      logic       store_n;
      logic       rd_n;
      logic       chan;
      logic       sample_trigger_n;
      logic       clear_n;
      logic [7:0] data;
   } dda_pins_t;

   // ----------------------------------------------------------------
   // Conversion sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {
      DDA_IDLE = 1'b0,
      DDA_CONV = 1'b1
   } dda_state_t;

endpackage

// File: design/dda_sync.sv
// Purpose: two-flop synchroniser for a bundle of pin levels.
// Assumes: each bit is an independent level.
// Notes:   first stage is read only by the second stage.
module dda_sync #(
   parameter int W = 14
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         reset,
   // Levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;

   initial begin
      if (W < 1) $error("dda_sync: width must be at least one");
   end

   // Two stages; idle reset value is all ones (inactive pins)
   always_ff @(posedge clk) begin
      if (reset) begin
         meta_reg <= {W{1'b1}};
         q        <= {W{1'b1}};
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end

endmodule

// File: design/dda_host_port.sv
// Purpose: host port of a dual output / single input 8-bit converter.
// Assumes: pins asynchronous to clk; comparator result on clk domain.
// Notes:   analog parts live outside; sar_trial feeds the comparator.
`include "dda_regs.svh"

module dda_host_port #(
   parameter int DIV = `DDA_CYC_PER_BIT
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 reset,
   // Host pins
   input  wire dda_pkg::dda_pins_t   pins,
   output logic [`DDA_DW-1:0]        data_out,
   output logic                      data_oe_n,
   output logic                      busy_n,
   output logic                      int_n,
   // Output latches
   output logic [`DDA_DW-1:0]        first_output_latch,
   output logic [`DDA_DW-1:0]        second_output_latch,
   // Analog side
   input  wire logic                 cmp_keep,
   output logic [`DDA_DW-1:0]        sar_trial,
   output logic                      track_hold
);
   import dda_pkg::*;

   localparam int CONV_CYC = `DDA_CONV_BITS * DIV;

   initial begin
      if (DIV < 1 || DIV >= (1 << `DDA_DIV_W))
         $error("dda_host_port: DIV out of range");
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic fell(input logic prev, input logic cur);
      fell = prev & ~cur;
   endfunction

   function automatic logic rose(input logic prev, input logic cur);
      rose = ~prev & cur;
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   dda_pins_t s;
   dda_pins_t p_reg;

   dda_sync #(.W($bits(dda_pins_t))) u_sync (
      .clk   (clk),
      .reset (reset),
      .d     (pins),
      .q     (s)
   );

   // Previous synced sample for edge detection
   always_ff @(posedge clk) begin
      if (reset) p_reg <= '1;
      else       p_reg <= s;
   end

   logic rd_act;
   logic rd_act_prev;
   logic store_edge;
   logic trig_fall;
   logic rd_fall;
   logic read_end;

   assign rd_act      = ~s.cs_n & ~s.rd_n;
   assign rd_act_prev = ~p_reg.cs_n & ~p_reg.rd_n;
   // Chip select taken from the sample before the edge, so a select arriving with the edge does not load
   assign store_edge  = rose(p_reg.store_n, s.store_n) & ~p_reg.cs_n;
   assign trig_fall   = fell(p_reg.sample_trigger_n, s.sample_trigger_n);
   assign rd_fall     = fell(p_reg.rd_n, s.rd_n) & ~s.cs_n;
   assign read_end    = fell(rd_act_prev, rd_act);

   // ----------------------------------------------------------------
   // Output latches
   // ----------------------------------------------------------------
   // Clear pin wins over a store in the same cycle
   always_ff @(posedge clk) begin
      if (reset || !s.clear_n) begin
         first_output_latch  <= `DDA_LATCH_RST;
         second_output_latch <= `DDA_LATCH_RST;
      end else if (store_edge) begin
         if (!p_reg.chan) first_output_latch  <= p_reg.data;
         else             second_output_latch <= p_reg.data;
      end
   end

   // ----------------------------------------------------------------
   // Mode detection
   // ----------------------------------------------------------------
   // A trigger that never falls is taken as tied high
   logic trig_seen_reg;

   always_ff @(posedge clk) begin
      if (reset)          trig_seen_reg <= 1'b0;
      else if (trig_fall) trig_seen_reg <= 1'b1;
   end

   logic mode2;
   assign mode2 = ~trig_seen_reg & s.sample_trigger_n;

   // ----------------------------------------------------------------
   // Conversion sequencer
   // ----------------------------------------------------------------
   dda_state_t          state_reg;
   logic [`DDA_DIV_W-1:0] div_reg;
   logic [2:0]          bit_reg;
   logic [`DDA_DW-1:0]  sar_reg;
   logic [`DDA_DW-1:0]  result_reg;
   logic                start;
   logic                tick;
   logic                done;
   logic [`DDA_DW-1:0]  sar_next;

   // A retrigger while busy is ignored rather than restarting
   assign start = (state_reg == DDA_IDLE) &
                  ((trig_fall & ~mode2) | (rd_fall & mode2));
   assign tick  = (state_reg == DDA_CONV) &&
                  (div_reg == `DDA_DIV_W'(DIV - 1));
   assign done  = tick && (bit_reg == `DDA_BIT_LSB);

   // Keep or drop current trial bit, then try the next lower one
   always_comb begin
      sar_next = sar_reg;
      if (!cmp_keep) sar_next[bit_reg] = 1'b0;
      if (bit_reg != `DDA_BIT_LSB) sar_next[bit_reg - 3'h1] = 1'b1;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= DDA_IDLE;
      end else begin
         unique case (state_reg)
            DDA_IDLE: if (start) state_reg <= DDA_CONV;
            DDA_CONV: if (done)  state_reg <= DDA_IDLE;
         endcase
      end
   end

   // Bit clock divider
   always_ff @(posedge clk) begin
      if (reset || state_reg == DDA_IDLE || tick) div_reg <= '0;
      else                                         div_reg <= div_reg + 1'b1;
   end

   // Eight bit decisions, MSB first
   always_ff @(posedge clk) begin
      if (reset) begin
         bit_reg <= `DDA_BIT_MSB;
         sar_reg <= `DDA_SAR_RST;
      end else if (start) begin
         bit_reg <= `DDA_BIT_MSB;
         sar_reg <= `DDA_SAR_MSB;
      end else if (done) begin
         sar_reg <= `DDA_SAR_RST;
      end else if (tick) begin
         bit_reg <= bit_reg - 3'h1;
         sar_reg <= sar_next;
      end
   end

   // Result only changes at the end, so old data shows meanwhile
   always_ff @(posedge clk) begin
      if (reset)     result_reg <= `DDA_LATCH_RST;
      else if (done) result_reg <= sar_next;
   end

   assign busy_n     = (state_reg == DDA_IDLE);
   assign track_hold = (state_reg == DDA_CONV);
   assign sar_trial  = sar_reg;

   // ----------------------------------------------------------------
   // Completion flag
   // ----------------------------------------------------------------
   // Completion beats a clear arriving in the same cycle
   always_ff @(posedge clk) begin
      if (reset)                        int_n <= 1'b1;
      else if (done)                    int_n <= 1'b0;
      else if (!s.clear_n || read_end)  int_n <= 1'b1;
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         data_out  <= `DDA_LATCH_RST;
         data_oe_n <= 1'b1;
      end else begin
         data_out  <= result_reg;
         data_oe_n <= ~rd_act;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   logic [15:0] busy_len;
   always_ff @(posedge clk) begin
      if (reset || busy_n) busy_len <= '0;
      else                 busy_len <= busy_len + 16'h1;
   end

   sequence s_store_first;
      store_edge && !p_reg.chan && s.clear_n;
   endsequence
   sequence s_store_second;
      store_edge && p_reg.chan && s.clear_n;
   endsequence

   property p_load_first;
      s_store_first |=> first_output_latch == $past(p_reg.data);
   endproperty
   a_load_first: assert property (p_load_first)
      else $error("first latch not loaded");

   property p_load_second;
      s_store_second |=> second_output_latch == $past(p_reg.data) &&
                         $stable(first_output_latch);
   endproperty
   a_load_second: assert property (p_load_second)
      else $error("second latch not loaded");

   property p_no_transparent;
      (!store_edge && s.clear_n) |=> $stable(first_output_latch) &&
                                     $stable(second_output_latch);
   endproperty
   a_no_transparent: assert property (p_no_transparent)
      else $error("latch changed without store edge");

   property p_pin_clear;
      (!s.clear_n && !done) |=> first_output_latch == `DDA_LATCH_RST &&
                     second_output_latch == `DDA_LATCH_RST && int_n;
   endproperty
   a_pin_clear: assert property (p_pin_clear)
      else $error("clear pin did not zero latches");

   sequence s_start1;
      busy_n && trig_fall && !mode2;
   endsequence
   property p_trig_start;
      s_start1 |=> !busy_n && track_hold;
   endproperty
   a_trig_start: assert property (p_trig_start)
      else $error("trigger did not start conversion");

   property p_conv_len;
      $rose(busy_n) |-> busy_len == CONV_CYC && !track_hold;
   endproperty
   a_conv_len: assert property (p_conv_len)
      else $error("conversion length wrong");

   property p_done_flag;
      $rose(busy_n) |-> !int_n && sar_trial == `DDA_SAR_RST;
   endproperty
   a_done_flag: assert property (p_done_flag)
      else $error("completion flag not set");

   property p_read_clear;
      (read_end && !done) |=> int_n;
   endproperty
   a_read_clear: assert property (p_read_clear)
      else $error("read end did not clear flag");

   property p_mode2_start;
      (busy_n && mode2 && rd_fall) |=> !busy_n ##[1:2] !busy_n;
   endproperty
   a_mode2_start: assert property (p_mode2_start)
      else $error("read did not start conversion");

   property p_old_data;
      (!busy_n && $past(!busy_n)) |-> ##1 $stable(data_out);
   endproperty
   a_old_data: assert property (p_old_data)
      else $error("data changed during conversion");

   property p_clear_keeps_conv;
      (!busy_n && !s.clear_n && !done) |=> !busy_n && int_n;
   endproperty
   a_clear_keeps_conv: assert property (p_clear_keeps_conv)
      else $error("clear pin disturbed conversion");

   property p_bus_drive;
      data_oe_n == !$past(rd_act);
   endproperty
   a_bus_drive: assert property (p_bus_drive)
      else $error("bus driven outside read");

endmodule

// File: tb/dda_master_model.sv
// Purpose: bus master and input comparator facing the converter host port.
// Assumes: called just after a falling clock edge; pins change only there.
// Notes:   a released data bus shows the inverse of the last byte written.
module dda_master_model (
   // Clock
   input  wire logic        clk,
   // Host pins driven by this master
   output dda_pkg::dda_pins_t pins,
   // Converter side
   input  wire logic [7:0]  sar_trial,
   input  wire logic        track_hold,
   output logic             cmp_keep
);
   timeunit 1ns;
   timeprecision 1ps;
   import dda_pkg::*;

   logic [7:0] vin;
   logic [7:0] vin_held;

   // Idle levels at time zero; trigger high until mode one is entered
   initial begin
      pins = '{cs_n: 1'h1, store_n: 1'h1, rd_n: 1'h1, chan: 1'h0,
               sample_trigger_n: 1'h1, clear_n: 1'h1, data: 8'hA5};
      vin = 8'h00;
   end

   // Input follows vin only while tracking, so changes in hold are ignored
   always_ff @(posedge clk) begin
      if (!track_hold) vin_held <= vin;
   end
   assign cmp_keep = (sar_trial <= vin_held);

   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Write cycle pieces, so a caller can stretch the low phase
   task automatic setup(input logic ch, input logic [7:0] d, input logic cs);
      pins.chan = ch;
      pins.data = d;
      pins.cs_n = cs;
      idle(4);
   endtask

   task automatic strobe(input logic lvl);
      pins.store_n = lvl;
      idle(4);
   endtask

   task automatic finish();
      pins.cs_n = 1'h1;
      pins.data = ~pins.data;
      idle(1);
   endtask

   task automatic wr(input logic ch, input logic [7:0] d, input logic cs);
      setup(ch, d, cs);
      strobe(1'h0);
      strobe(1'h1);
      finish();
   endtask

   // Read strobes; caller keeps the trigger low in mode one
   task automatic rd_on();
      pins.cs_n = 1'h0;
      pins.rd_n = 1'h0;
   endtask

   task automatic rd_off();
      pins.rd_n = 1'h1;
      pins.cs_n = 1'h1;
   endtask

   task automatic trig(input logic lvl);
      pins.sample_trigger_n = lvl;
   endtask

   task automatic clr();
      pins.clear_n = 1'h0;
      idle(4);
      pins.clear_n = 1'h1;
      idle(4);
   endtask
endmodule

// File: tb/dda_host_port_bench.sv
// Purpose: self-checking bench of the converter host port.
// Assumes: DIV shortened to 2, so one conversion lasts 16 clocks.
// Notes:   pins change at the falling edge; outputs are sampled there.
`define CHECK_EQ(what, exp, got) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) begin \
         fail_count++; \
         $display("unexpected %s: expected %0h, seen %0h", what, exp, got); \
      end \
   end

module dda_host_port_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import dda_pkg::*;

   localparam int DIV = 2;
   logic       clk;
   logic       reset;
   dda_pins_t  pins;
   logic [7:0] data_out;
   logic [7:0] first_output_latch;
   logic [7:0] second_output_latch;
   logic [7:0] sar_trial;
   logic       data_oe_n;
   logic       busy_n;
   logic       int_n;
   logic       cmp_keep;
   logic       track_hold;
   int         fail_count;
   int         cmp_count;
   logic [7:0] exp_a;
   logic [7:0] exp_b;
   logic [7:0] prev;
   logic [7:0] vin_now;
   logic [7:0] d;
   logic       ch;
   logic       cs;
   logic       clr_mid;

   dda_host_port #(.DIV(DIV)) dda_host_port_inst (
      .clk(clk), .reset(reset), .pins(pins), .data_out(data_out),
      .data_oe_n(data_oe_n), .busy_n(busy_n), .int_n(int_n),
      .first_output_latch(first_output_latch),
      .second_output_latch(second_output_latch),
      .cmp_keep(cmp_keep), .sar_trial(sar_trial), .track_hold(track_hold));

   dda_master_model dda_master_model_inst (
      .clk(clk), .pins(pins), .sar_trial(sar_trial),
      .track_hold(track_hold), .cmp_keep(cmp_keep));

   // Free-running 25 MHz clock
   always #20 clk = ~clk;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic print_verdict();
      if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask

   // A wait that used up its bound ends the run at once
   task automatic guard(input int n, input int lim);
      if (n >= lim) begin
         fail_count++;
         print_verdict();
      end
   endtask

   // Waits for a conversion, checks hold, old data, length and completion
   task automatic conv(input logic [7:0] old);
      int n;
      n = 0;
      while (busy_n !== 1'h0 && n < 20) begin
         idle(1);
         n++;
      end
      guard(n, 20);
      `CHECK_EQ("hold", 1'h1, track_hold)
      `CHECK_EQ("old data", old, data_out)
      `CHECK_EQ("first trial", 8'h80, sar_trial)
      dda_master_model_inst.vin = ~vin_now;
      n = 0;
      while (busy_n === 1'h0 && n < 1000) begin
         // Optional clear pulse mid-conversion must not disturb it
         dda_master_model_inst.pins.clear_n = !(clr_mid && n inside {[2:4]});
         idle(1);
         n++;
      end
      guard(n, 1000);
      `CHECK_EQ("busy length", 8 * DIV, n)
      `CHECK_EQ("tracking", 1'h0, track_hold)
      `CHECK_EQ("trial cleared", 8'h00, sar_trial)
      `CHECK_EQ("done flag", 1'h0, int_n)
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'h2d9355fd));
      clk = 1'h0;
      reset = 1'h1;
      fail_count = 0;
      cmp_count = 0;
      clr_mid = 1'h0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      reset = 1'h0;
      idle(3);
      `CHECK_EQ("first latch", 8'h00, first_output_latch)
      `CHECK_EQ("second latch", 8'h00, second_output_latch)
      `CHECK_EQ("done flag", 1'h1, int_n)
      `CHECK_EQ("bus enable", 1'h1, data_oe_n)

      // Writes; one with chip select high must be ignored
      exp_a = 8'h00;
      exp_b = 8'h00;
      for (int i = 0; i < 6; i++) begin
         ch = (i < 2) ? i[0] : 1'($urandom);
         d = (i < 2) ? 8'hFF : 8'($urandom);
         cs = (i == 4);
         dda_master_model_inst.wr(ch, d, cs);
         idle(2);
         if (!cs && ch) exp_b = d;
         if (!cs && !ch) exp_a = d;
         `CHECK_EQ("first latch", exp_a, first_output_latch)
         `CHECK_EQ("second latch", exp_b, second_output_latch)
      end

      // Strobe held low while data moves: no transparency
      dda_master_model_inst.setup(1'h1, 8'h3C, 1'h0);
      dda_master_model_inst.strobe(1'h0);
      dda_master_model_inst.pins.data = 8'hC3;
      idle(6);
      `CHECK_EQ("second latch", exp_b, second_output_latch)
      dda_master_model_inst.strobe(1'h1);
      dda_master_model_inst.finish();
      `CHECK_EQ("second latch", 8'hC3, second_output_latch)

      // Mode two: trigger never fell, a read starts each conversion
      prev = 8'h00;
      for (int i = 0; i < 3; i++) begin
         vin_now = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
         dda_master_model_inst.vin = vin_now;
         dda_master_model_inst.rd_on();
         conv(prev);
         idle(1);
         `CHECK_EQ("read data", vin_now, data_out)
         `CHECK_EQ("bus enable", 1'h0, data_oe_n)
         dda_master_model_inst.rd_off();
         idle(4);
         `CHECK_EQ("bus enable", 1'h1, data_oe_n)
         `CHECK_EQ("done flag", 1'h1, int_n)
         prev = vin_now;
      end

      // Mode one: trigger held low through conversion and read
      for (int i = 0; i < 4; i++) begin
         vin_now = (i == 0) ? 8'h80 : 8'($urandom);
         dda_master_model_inst.vin = vin_now;
         dda_master_model_inst.trig(1'h0);
         clr_mid = (i == 1);
         conv(prev);
         clr_mid = 1'h0;
         if (i == 1) begin
            dda_master_model_inst.clr();
            `CHECK_EQ("done flag", 1'h1, int_n)
            `CHECK_EQ("first latch", 8'h00, first_output_latch)
            `CHECK_EQ("second latch", 8'h00, second_output_latch)
         end
         dda_master_model_inst.rd_on();
         idle(4);
         `CHECK_EQ("bus enable", 1'h0, data_oe_n)
         `CHECK_EQ("read data", vin_now, data_out)
         `CHECK_EQ("done flag", (i == 1), int_n)
         dda_master_model_inst.rd_off();
         idle(4);
         `CHECK_EQ("done flag", 1'h1, int_n)
         `CHECK_EQ("bus enable", 1'h1, data_oe_n)
         dda_master_model_inst.trig(1'h1);
         idle(4);
         prev = vin_now;
      end
      print_verdict();
   end
endmodule
